// *** src/fracn_feedback_divider_ctl.v ***
`timescale 1ns/1ns
`include "fracn_defs.vh"
// serial-programmed feedback divider of a fractional-N synthesizer.
// rf and reference inputs are pin-rate signals sampled on SYS_CLK;
// the prescaler is modelled as a count of rf edges.
module fracn_feedback_divider_ctl #(
  parameter REF_DIV = 16'h0003
) (
  input wire SYS_CLK,
  input wire SRST,
  input wire SER_CLK,
  input wire SER_DATA,
  input wire LATCH_ENABLE,
  input wire RF_DIVIDER_INPUT,
  input wire REFERENCE_INPUT_PIN,
  input wire CP_PULSE_ACTIVE,
  output reg FEEDBACK_OUT,
  output reg REFERENCE_OUT,
  output reg RF_INPUT_ENABLE,
  output reg REF_INPUT_ENABLE,
  output reg CP_OUTPUT_ENABLE,
  output reg PHASE_COMP_ENABLE,
  output reg POWERED_DOWN,
  output reg [9:0] MAIN_PROGRAMMABLE_COUNT,
  output reg [4:0] PULSE_SWALLOW_COUNT,
  output reg [3:0] FRACTIONAL_NUMERATOR,
  output reg PRESCALER_MODULUS_SELECT,
  output reg COUNTER_RESET_BIT,
  output reg FRACTIONAL_MODULUS_SELECT,
  output reg [2:0] LOCK_DETECT_OUTPUT_SELECT,
  output reg POWER_DOWN_TIMING_SELECT
);
  wire sclk_s;
  wire sdat_s;
  wire le_s;
  wire rf_s;
  wire ref_s;
  reg sclk_prev_q;
  reg le_prev_q;
  reg rf_prev_q;
  reg ref_prev_q;
  reg [`WORD_W-1:0] shift_q;
  reg power_down_bit_q;
  reg [15:0] ref_cnt_q;
  reg [5:0] pre_cnt_q;
  reg [9:0] main_cnt_q;
  reg [4:0] swal_cnt_q;
  reg [4:0] acc_q;
  reg extra_q;
  reg [4:0] acc_sum;
  reg [4:0] modulus;
  wire cp_s;
  wire run;
  wire sclk_rise;
  wire le_rise;
  wire rf_rise;
  wire ref_rise;
  wire [5:0] pre_mod;

  // pin inputs cross into SYS_CLK
  pin_sync u_sclk (.clk(SYS_CLK), .srst(SRST), .din(SER_CLK), .dout(sclk_s));
  pin_sync u_sdat (.clk(SYS_CLK), .srst(SRST), .din(SER_DATA), .dout(sdat_s));
  pin_sync u_le (.clk(SYS_CLK), .srst(SRST), .din(LATCH_ENABLE), .dout(le_s));
  pin_sync u_rf (.clk(SYS_CLK), .srst(SRST), .din(RF_DIVIDER_INPUT), .dout(rf_s));
  pin_sync u_ref (.clk(SYS_CLK), .srst(SRST), .din(REFERENCE_INPUT_PIN), .dout(ref_s));
  pin_sync u_cp (.clk(SYS_CLK), .srst(SRST), .din(CP_PULSE_ACTIVE), .dout(cp_s));

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign le_rise = le_s & ~le_prev_q;
  // counters stop while powered down or in counter reset
  assign run = ~POWERED_DOWN & ~COUNTER_RESET_BIT;
  assign rf_rise = rf_s & ~rf_prev_q & run;
  assign ref_rise = ref_s & ~ref_prev_q & run;
  assign pre_mod = PRESCALER_MODULUS_SELECT ? `P_HI : `P_LO;

  // modulus and unwrapped accumulator sum
  always @* begin
    modulus = FRACTIONAL_MODULUS_SELECT ? `MOD_HI : `MOD_LO;
    acc_sum = acc_q + {1'b0, FRACTIONAL_NUMERATOR};
  end

  // edge history
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sclk_prev_q <= 1'b0;
      le_prev_q <= 1'b0;
      rf_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      le_prev_q <= le_s;
      rf_prev_q <= rf_s;
      ref_prev_q <= ref_s;
    end
  end

  // serial port: msb first, address in the two lsbs; never gated by power-down
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      shift_q <= {`WORD_W{1'b0}};
      MAIN_PROGRAMMABLE_COUNT <= 10'h003;
      PULSE_SWALLOW_COUNT <= 5'h00;
      FRACTIONAL_NUMERATOR <= 4'h0;
      PRESCALER_MODULUS_SELECT <= 1'b0;
      power_down_bit_q <= 1'b0;
      COUNTER_RESET_BIT <= 1'b0;
      FRACTIONAL_MODULUS_SELECT <= 1'b0;
      LOCK_DETECT_OUTPUT_SELECT <= 3'h0;
      POWER_DOWN_TIMING_SELECT <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_q <= {shift_q[`WORD_W-2:0], sdat_s};
      end
      if (le_rise) begin
        case (shift_q[1:0])
          `ADDR_DIV: begin
            FRACTIONAL_NUMERATOR <= shift_q[`FRAC_MSB:`FRAC_LSB];
            PULSE_SWALLOW_COUNT <= shift_q[`SWAL_MSB:`SWAL_LSB];
            MAIN_PROGRAMMABLE_COUNT <= shift_q[`MAIN_MSB:`MAIN_LSB];
            PRESCALER_MODULUS_SELECT <= shift_q[`PRESC_BIT];
            power_down_bit_q <= shift_q[`POWER_DOWN_BIT_BIT];
            COUNTER_RESET_BIT <= shift_q[`CRST_BIT];
          end
          `ADDR_CFG: begin
            FRACTIONAL_MODULUS_SELECT <= shift_q[`FMOD_BIT];
            LOCK_DETECT_OUTPUT_SELECT <= shift_q[`LOCK_DETECT_OUTPUT_SELECT_MSB:`LOCK_DETECT_OUTPUT_SELECT_LSB];
          end
          `ADDR_OUT: begin
            POWER_DOWN_TIMING_SELECT <= shift_q[`PDT_BIT];
          end
          default: begin
            // reference word is not latched; REF_DIV is a fixed parameter
          end
        endcase
      end
    end
  end

  // power-down entry: immediate, or after the pump pulse ends in sync mode
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      POWERED_DOWN <= 1'b0;
    end else if (!power_down_bit_q) begin
      POWERED_DOWN <= 1'b0;
    end else if (!POWER_DOWN_TIMING_SELECT) begin
      POWERED_DOWN <= 1'b1;
    end else if (!POWERED_DOWN) begin
      // a pulse ending, or no pulse at all, lets power-down in
      if (!cp_s) begin
        POWERED_DOWN <= 1'b1;
      end
    end
  end

  // enables of the floating pins follow power-down
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      RF_INPUT_ENABLE <= 1'b1;
      REF_INPUT_ENABLE <= 1'b1;
      CP_OUTPUT_ENABLE <= 1'b1;
      PHASE_COMP_ENABLE <= 1'b1;
    end else begin
      RF_INPUT_ENABLE <= ~POWERED_DOWN;
      REF_INPUT_ENABLE <= ~POWERED_DOWN;
      CP_OUTPUT_ENABLE <= ~POWERED_DOWN;
      PHASE_COMP_ENABLE <= ~POWERED_DOWN;
    end
  end

  // reference counter; reset alongside the feedback chain
  always @(posedge SYS_CLK) begin
    if (SRST || COUNTER_RESET_BIT) begin
      ref_cnt_q <= 16'h0000;
      REFERENCE_OUT <= 1'b0;
    end else begin
      REFERENCE_OUT <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt_q >= REF_DIV - 16'h0001) begin
          ref_cnt_q <= 16'h0000;
          REFERENCE_OUT <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q + 16'h0001;
        end
      end
    end
  end

  // pulse-swallow feedback chain: P+1 rf edges while swallow runs, P after.
  // all state clears on counter reset so restart lines up with the reference
  always @(posedge SYS_CLK) begin
    if (SRST || COUNTER_RESET_BIT) begin
      pre_cnt_q <= 6'h00;
      main_cnt_q <= 10'h000;
      swal_cnt_q <= 5'h00;
      acc_q <= 5'h00;
      extra_q <= 1'b0;
      FEEDBACK_OUT <= 1'b0;
    end else begin
      FEEDBACK_OUT <= 1'b0;
      if (rf_rise) begin
        // one prescaler cycle is P, P+1 while swallowing, +1 on overflow
        if (pre_cnt_q < pre_mod - 6'h01 + {5'h00, swal_cnt_q != 5'h00}
            + {5'h00, extra_q}) begin
          pre_cnt_q <= pre_cnt_q + 6'h01;
        end else begin
          pre_cnt_q <= 6'h00;
          extra_q <= 1'b0;
          if (swal_cnt_q != 5'h00) begin
            swal_cnt_q <= swal_cnt_q - 5'h01;
          end
          if (main_cnt_q >= MAIN_PROGRAMMABLE_COUNT - 10'h001) begin
            main_cnt_q <= 10'h000;
            swal_cnt_q <= PULSE_SWALLOW_COUNT;
            FEEDBACK_OUT <= 1'b1;
            // fractional step once per feedback period
            if (acc_sum >= modulus) begin
              acc_q <= acc_sum - modulus;
              extra_q <= 1'b1;
            end else begin
              acc_q <= acc_sum;
            end
          end else begin
            main_cnt_q <= main_cnt_q + 10'h001;
          end
        end
      end
    end
  end
endmodule // fracn_feedback_divider_ctl

// *** src/fracn_defs.vh ***
`ifndef FRACN_DEFS_VH
`define FRACN_DEFS_VH
`define WORD_W 24
`define ADDR_CFG 2'h0
`define ADDR_OUT 2'h1
`define ADDR_REF 2'h2
`define ADDR_DIV 2'h3
`define FRAC_LSB 2
`define FRAC_MSB 5
`define SWAL_LSB 6
`define SWAL_MSB 10
`define MAIN_LSB 11
`define MAIN_MSB 20
`define PRESC_BIT 21
`define POWER_DOWN_BIT_BIT 22
`define CRST_BIT 23
`define LOCK_DETECT_OUTPUT_SELECT_LSB 19
`define LOCK_DETECT_OUTPUT_SELECT_MSB 21
`define FMOD_BIT 22
`define PDT_BIT 21
`define MOD_LO 5'h0f
`define MOD_HI 5'h10
`define P_LO 6'h10
`define P_HI 6'h20
`endif

// *** src/pin_sync.v ***
`timescale 1ns/1ns
// three-stage synchroniser; a change counts when stages two and three agree
module pin_sync (
  input wire clk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // s1 only feeds s2 so metastability cannot leak into logic
  always @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // pin_sync

// *** dv/fracn_host_model.sv ***
`timescale 1ns/1ns
// host end of the three-wire port; link clock rests low between words
module fracn_host_model (
  input wire clk,
  output logic sclk = 1'b0,
  output logic sdata = 1'b0,
  output logic le = 1'b0
);
  // 80 ns link clock; data is set a half period ahead of the rising edge
  task automatic send(input logic [23:0] w);
    @(posedge clk);
    // data moves with the falling link clock so the period stays 80 ns
    for (int i = 23; i >= 0; i--) begin
      sdata <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    sdata <= ~w[0]; // inverted last bit, so a stale bit cannot pass
    le <= 1'b1;
    repeat (8) @(posedge clk);
    le <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // fracn_host_model

// *** dv/fracn_feedback_divider_ctl_assertions.sv ***
`timescale 1ns/1ns
// port checks; held fields may only move shortly after a latch pulse
module fracn_divider_checker (
  input wire SYS_CLK, SRST, LATCH_ENABLE, FEEDBACK_OUT, REFERENCE_OUT, POWERED_DOWN,
  input wire RF_INPUT_ENABLE, REF_INPUT_ENABLE, CP_OUTPUT_ENABLE, PHASE_COMP_ENABLE,
  input wire PRESCALER_MODULUS_SELECT, COUNTER_RESET_BIT, FRACTIONAL_MODULUS_SELECT,
  input wire POWER_DOWN_TIMING_SELECT,
  input wire [9:0] MAIN_PROGRAMMABLE_COUNT,
  input wire [4:0] PULSE_SWALLOW_COUNT,
  input wire [3:0] FRACTIONAL_NUMERATOR,
  input wire [2:0] LOCK_DETECT_OUTPUT_SELECT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  AST_PD_IN: assert property (
    $past(POWERED_DOWN) |-> !RF_INPUT_ENABLE && !REF_INPUT_ENABLE) else $error("input on");
  AST_PD_CP: assert property (
    $past(POWERED_DOWN) |-> !CP_OUTPUT_ENABLE && !PHASE_COMP_ENABLE) else $error("pump on");
  AST_UP: assert property (
    !$past(POWERED_DOWN) |-> RF_INPUT_ENABLE && CP_OUTPUT_ENABLE) else $error("off while up");
  AST_FB_PD: assert property (
    POWERED_DOWN && $past(POWERED_DOWN, 2) |-> !FEEDBACK_OUT) else $error("count in pd");
  AST_CRST: assert property (
    COUNTER_RESET_BIT && $past(COUNTER_RESET_BIT, 2) |-> !FEEDBACK_OUT && !REFERENCE_OUT)
    else $error("count in reset");
  AST_FB_PULSE: assert property (FEEDBACK_OUT |=> !FEEDBACK_OUT)
    else $error("long pulse");
  AST_DIV_LOAD: assert property (
    !$stable({MAIN_PROGRAMMABLE_COUNT, PULSE_SWALLOW_COUNT, FRACTIONAL_NUMERATOR,
    PRESCALER_MODULUS_SELECT, COUNTER_RESET_BIT}) |-> $past(LATCH_ENABLE, 4))
    else $error("div moved");
  AST_CFG_LOAD: assert property (
    !$stable({FRACTIONAL_MODULUS_SELECT, LOCK_DETECT_OUTPUT_SELECT, POWER_DOWN_TIMING_SELECT})
    |-> $past(LATCH_ENABLE, 4)) else $error("cfg moved");
  C_PD: cover property ($rose(POWERED_DOWN));
  C_FB: cover property (FEEDBACK_OUT);
  C_CRST: cover property ($rose(COUNTER_RESET_BIT));
endmodule // fracn_divider_checker

// *** dv/testbench.sv ***
`timescale 1ns/1ns
// held words are modelled as vectors and compared with the ports after each load
module testbench;
  logic SYS_CLK = 1'b0, SRST = 1'b1, RF_DIVIDER_INPUT = 1'b0, REFERENCE_INPUT_PIN = 1'b1;
  logic CP_PULSE_ACTIVE = 1'b0, SER_CLK, SER_DATA, LATCH_ENABLE, FEEDBACK_OUT, REFERENCE_OUT;
  logic RF_INPUT_ENABLE, REF_INPUT_ENABLE, CP_OUTPUT_ENABLE, PHASE_COMP_ENABLE, POWERED_DOWN;
  logic PRESCALER_MODULUS_SELECT, COUNTER_RESET_BIT, FRACTIONAL_MODULUS_SELECT;
  logic POWER_DOWN_TIMING_SELECT;
  logic [9:0] MAIN_PROGRAMMABLE_COUNT;
  logic [4:0] PULSE_SWALLOW_COUNT;
  logic [3:0] FRACTIONAL_NUMERATOR;
  logic [2:0] LOCK_DETECT_OUTPUT_SELECT, ph = 3'h0;
  logic [23:0] mdiv = 24'h001800, mcfg = 24'h000000, mout = 24'h000000;
  logic [31:0] seed = 32'h00013975;
  int n_mismatch = 0, n_checks = 0;
  fracn_feedback_divider_ctl fracn_feedback_divider_ctl_inst (.*);
  fracn_host_model fracn_host_model_inst (.clk(SYS_CLK), .sclk(SER_CLK), .sdata(SER_DATA),
    .le(LATCH_ENABLE));
  always #5 SYS_CLK = ~SYS_CLK;
  // rf and reference pins toggle every 40 ns
  always @(posedge SYS_CLK) begin
    ph <= ph + 3'h1;
    RF_DIVIDER_INPUT <= ph[2];
    REFERENCE_INPUT_PIN <= ~ph[2];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fields;
    logic pd;
    pd = mdiv[22] & ~(mout[21] & CP_PULSE_ACTIVE);
    chk("main", MAIN_PROGRAMMABLE_COUNT, mdiv[20:11]);
    chk("swallow", PULSE_SWALLOW_COUNT, mdiv[10:6]);
    chk("frac", FRACTIONAL_NUMERATOR, mdiv[5:2]);
    chk("ctl", {COUNTER_RESET_BIT, PRESCALER_MODULUS_SELECT}, {mdiv[23], mdiv[21]});
    chk("cfg", {FRACTIONAL_MODULUS_SELECT, LOCK_DETECT_OUTPUT_SELECT}, mcfg[22:19]);
    chk("timing", POWER_DOWN_TIMING_SELECT, mout[21]);
    chk("pd", POWERED_DOWN, pd);
    chk("ena", {RF_INPUT_ENABLE, REF_INPUT_ENABLE, CP_OUTPUT_ENABLE, PHASE_COMP_ENABLE},
      {4{~pd}});
  endtask
  // the reference address is not held here, so such a word leaves the model alone
  task automatic put(input logic [23:0] w);
    fracn_host_model_inst.send(w);
    if (w[1:0] == 2'h3) mdiv = w;
    if (w[1:0] == 2'h0) mcfg = w;
    if (w[1:0] == 2'h1) mout = w;
    fields();
  endtask
  // a whole accumulator cycle of m periods carries exactly k extra rf edges
  task automatic period(input int m, p, k);
    int cyc;
    cyc = 0;
    @(posedge SYS_CLK iff FEEDBACK_OUT === 1'b1);
    for (int i = 0; i < m; i++) begin
      do begin
        @(posedge SYS_CLK);
        cyc++;
      end while (FEEDBACK_OUT !== 1'b1);
    end
    chk("period", cyc, 8 * (m * (p * 3 + 1) + k));
  endtask
  // reference pulses come every REF_DIV (default 3) reference edges of 80 ns
  task automatic ref_gap;
    int cyc;
    cyc = 0;
    @(posedge SYS_CLK iff REFERENCE_OUT === 1'b1);
    do begin
      @(posedge SYS_CLK);
      cyc++;
    end while (REFERENCE_OUT !== 1'b1);
    chk("ref", cyc, 24);
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a set main msb in the random words, and main 3 elsewhere, keep every host word legal
  initial begin
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    fields();
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      put({2'h0, seed[0], 1'b1, seed[14:6], 1'b0, seed[5:2], seed[19:16], 2'h3});
    end
    put({seed[23:2], 2'h2});
    for (int j = 0; j < 4; j++) put({1'b0, j[0], j[1] ? {2'h3, j[0]} : {1'b0, j[0], 1'b0},
      19'h0});
    put({3'h4, 10'h003, 5'h01, 4'h0, 2'h3});
    put(24'h400000);
    put({3'h0, 10'h003, 5'h01, seed[3:0], 2'h3});
    period(16, 16, seed[3:0]);
    ref_gap();
    put(24'h000000);
    put({3'h1, 10'h003, 5'h01, 1'b0, seed[6:4], 2'h3});
    period(15, 32, seed[6:4]);
    put({3'h2, 10'h003, 5'h01, 4'h0, 2'h3});
    put(24'h700000);
    put(24'h200001);
    put(24'h001803);
    CP_PULSE_ACTIVE <= 1'b1;
    put({3'h2, 10'h003, 5'h01, 4'h0, 2'h3});
    CP_PULSE_ACTIVE <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
    fields();
    wrap_up();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    n_mismatch++;
    wrap_up();
  end
endmodule // testbench
bind fracn_feedback_divider_ctl fracn_divider_checker chk_inst (.*);
